// ---- audio_amp_config_registers.sv ----
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - switching rate field: 8,10,38,44,48 times fs; codes 010-100 reserved; reset 110
// - oversample bit: clear 64x, set 128x; resets clear
// - phase offset field: 0,30,45,60 degrees; resets to 45-degree code
// - input rate bits 7-6: 44.1, 48, 96 kHz; 11 reserved; reset 00
// - eight-slot TDM: first four slots when clear, last four when set
// - slot width bit: clear 24/32-bit, set 16-bit; resets clear
// - pair swap set: channels 1/2 use slots of channels 3/4, and reverse
// - serial format: RJ24/20/18/16, I2S, left-justified, DSP; 111 reserved; reset 100
// - channel 1 state bits 7-6: play, hi-z, mute, DC diagnostics; reset hi-z
// - channel 2 state bits 5-4: same encoding; reset hi-z
// - 8-bit gain, 0.5 dB steps, 0xff +24 dB, 0xcf 0 dB; reset 0xcf
// - gain 0x07 is -100 dB; below 0x07 mutes the channel
// - channel 1 gain at 0x05, channel 2 gain at 0x06, each own code
// - gain ramps one step per 1, 2, 4 or 8 frame syncs; reset 1
module audio_amp_config_registers
  import amp_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic frameSyncPulse,
  output switching_cfg_t switchingCfg,
  output serial_cfg_t serialCfg,
  output chan_state_t chanState,
  output logic [7:0] ch1GainCode,
  output logic [7:0] ch2GainCode,
  output logic ch1Muted,
  output logic ch2Muted
);
  logic [7:0] switching_r;
  logic [7:0] serial_r;
  logic [7:0] chState_r;
  logic [7:0] gain1_r;
  logic [7:0] gain2_r;
  logic [7:0] ramp_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] rampRate;
  logic [5:0] switchMult;
  logic [5:0] phaseDeg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  always_ff @(posedge mclk) begin
    if (rst) begin
      switching_r <= RST_SWITCHING;
      serial_r <= RST_SERIAL;
      chState_r <= RST_CHSTATE;
      gain1_r <= RST_GAIN;
      gain2_r <= RST_GAIN;
      ramp_r <= RST_RAMP;
    end else if (regWrite) begin
      // reserved bits of the switching register stay zero
      if (hit(regAddr, ADDR_SWITCHING)) switching_r <= regWdata & MASK_SWITCHING;
      if (hit(regAddr, ADDR_SERIAL)) serial_r <= regWdata;
      if (hit(regAddr, ADDR_CHSTATE)) chState_r <= regWdata;
      if (hit(regAddr, ADDR_GAIN1)) gain1_r <= regWdata;
      if (hit(regAddr, ADDR_GAIN2)) gain2_r <= regWdata;
      if (hit(regAddr, ADDR_RAMP)) ramp_r <= regWdata;
    end
  end

  assign rdata_nxt = hit(regAddr, ADDR_SWITCHING) ? switching_r :
                    hit(regAddr, ADDR_SERIAL) ? serial_r :
                    hit(regAddr, ADDR_CHSTATE) ? chState_r :
                    hit(regAddr, ADDR_GAIN1) ? gain1_r :
                    hit(regAddr, ADDR_GAIN2) ? gain2_r :
                    hit(regAddr, ADDR_RAMP) ? ramp_r : ZERO8;

  always_ff @(posedge mclk) begin
    if (rst) rdata_r <= ZERO8;
    else rdata_r <= rdata_nxt;
  end
  assign regRdata = rdata_r;

  // reserved switching codes fall back to a zero multiple, flagged invalid
  always_comb begin
    case (switching_r[6:4])
      SW_X8: switchMult = 6'd8;
      SW_X10: switchMult = 6'd10;
      SW_X38: switchMult = 6'd38;
      SW_X44: switchMult = 6'd44;
      SW_X48: switchMult = 6'd48;
      default: switchMult = 6'd0;
    endcase
  end

  always_comb begin
    case (switching_r[1:0])
      2'h0: phaseDeg = 6'd0;
      2'h1: phaseDeg = 6'd30;
      2'h2: phaseDeg = 6'd45;
      default: phaseDeg = 6'd60;
    endcase
  end

  assign switchingCfg.switchRateSel = switching_r[6:4];
  assign switchingCfg.switchMultiple = switchMult;
  assign switchingCfg.switchRateValid = switchMult != 6'd0;
  assign switchingCfg.modulatorOversampleSelect = switching_r[2];
  assign switchingCfg.oversampleRatio = switching_r[2] ? 8'd128 : 8'd64;
  assign switchingCfg.phaseOffsetSel = switching_r[1:0];
  assign switchingCfg.phaseOffsetDeg = phaseDeg;

  assign serialCfg.inputRateSelect = serial_r[7:6];
  assign serialCfg.inputRateValid = serial_r[7:6] != 2'h3;
  assign serialCfg.eightSlotHalfSelect = serial_r[5];
  assign serialCfg.slotWidth16 = serial_r[4];
  assign serialCfg.pairSwap = serial_r[3];
  assign serialCfg.serialFormat = serial_r[2:0];
  assign serialCfg.serialFormatValid = serial_r[2:0] != 3'h7;

  assign chanState.ch1OperatingState = op_state_t'(chState_r[7:6]);
  assign chanState.ch2OperatingState = op_state_t'(chState_r[5:4]);

  assign rampRate = ramp_r[3:2];

  gain_ramp ramp1 (
    .mclk(mclk),
    .rst(rst),
    .frameSyncPulse(frameSyncPulse),
    .rampRate(rampRate),
    .targetCode(gain1_r),
    .currentCode(ch1GainCode),
    .channelMuted(ch1Muted)
  );
  gain_ramp ramp2 (
    .mclk(mclk),
    .rst(rst),
    .frameSyncPulse(frameSyncPulse),
    .rampRate(rampRate),
    .targetCode(gain2_r),
    .currentCode(ch2GainCode),
    .channelMuted(ch2Muted)
  );

  switch_reset_a: assert property (@(posedge mclk)
    $past(rst) |-> switchMult == 6'd44 && phaseDeg == 6'd45
      && !switchingCfg.modulatorOversampleSelect)
    else $error("switching setup reset value wrong");
  // ties the ratio to the written bit, not to the stored copy
  oversample_map_a: assert property (@(posedge mclk) disable iff (rst)
    regWrite && hit(regAddr, ADDR_SWITCHING)
      |=> switchingCfg.oversampleRatio == ($past(regWdata[2]) ? 8'd128 : 8'd64))
    else $error("oversample ratio mismatch");
  phase_write_a: assert property (@(posedge mclk) disable iff (rst)
    regWrite && hit(regAddr, ADDR_SWITCHING) && regWdata[1:0] == 2'h3
      |=> phaseDeg == 6'd60)
    else $error("phase offset not applied");
  serial_reset_a: assert property (@(posedge mclk)
    $past(rst) |-> serialCfg.serialFormat == 3'h4 && serialCfg.inputRateSelect == 2'h0
      && !serialCfg.slotWidth16)
    else $error("serial setup reset value wrong");
  serial_write_a: assert property (@(posedge mclk) disable iff (rst)
    regWrite && hit(regAddr, ADDR_SERIAL) |=> serialCfg.pairSwap == $past(regWdata[3])
      && serialCfg.eightSlotHalfSelect == $past(regWdata[5]))
    else $error("slot options not stored");
  chan_reset_a: assert property (@(posedge mclk)
    $past(rst) |-> chanState.ch1OperatingState == ST_HIZ
      && chanState.ch2OperatingState == ST_HIZ)
    else $error("channel state reset wrong");
  gain_isolate_a: assert property (@(posedge mclk) disable iff (rst)
    regWrite && hit(regAddr, ADDR_GAIN1) |=> $stable(gain2_r))
    else $error("channel 1 write touched channel 2");
  mute_below_a: assert property (@(posedge mclk) disable iff (rst)
    ch1GainCode < GAIN_MUTE_BELOW |-> ch1Muted)
    else $error("channel 1 not muted below 0x07");
  gain_readback_a: assert property (@(posedge mclk) disable iff (rst)
    !regWrite && hit(regAddr, ADDR_GAIN2) ##1 !regWrite |-> regRdata == gain2_r)
    else $error("gain readback wrong");
endmodule
`default_nettype wire

// ---- amp_cfg_pkg.sv ----
package amp_cfg_pkg;
  localparam logic [7:0] ADDR_SWITCHING = 8'h02;
  localparam logic [7:0] ADDR_SERIAL = 8'h03;
  localparam logic [7:0] ADDR_CHSTATE = 8'h04;
  localparam logic [7:0] ADDR_GAIN1 = 8'h05;
  localparam logic [7:0] ADDR_GAIN2 = 8'h06;
  localparam logic [7:0] ADDR_RAMP = 8'h01;
  localparam logic [7:0] RST_SWITCHING = 8'h62;
  localparam logic [7:0] RST_SERIAL = 8'h04;
  localparam logic [7:0] RST_CHSTATE = 8'h55;
  localparam logic [7:0] RST_GAIN = 8'hcf;
  localparam logic [7:0] RST_RAMP = 8'h32;
  localparam logic [7:0] MASK_SWITCHING = 8'h77;
  localparam logic [7:0] GAIN_MUTE_BELOW = 8'h07;
  localparam logic [7:0] GAIN_UNITY = 8'hcf;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [3:0] ONE4 = 4'h1;
  localparam logic [3:0] ZERO4 = 4'h0;
  localparam logic [7:0] ONE8 = 8'h01;

  typedef enum logic [2:0] {
    SW_X8 = 3'h0, SW_X10 = 3'h1, SW_X38 = 3'h5, SW_X44 = 3'h6, SW_X48 = 3'h7
  } switch_rate_t;

  typedef enum logic [1:0] {
    ST_PLAY = 2'h0, ST_HIZ = 2'h1, ST_MUTE = 2'h2, ST_DIAG = 2'h3
  } op_state_t;

  typedef struct packed {
    logic [2:0] switchRateSel;
    logic [5:0] switchMultiple;
    logic switchRateValid;
    logic modulatorOversampleSelect;
    logic [7:0] oversampleRatio;
    logic [1:0] phaseOffsetSel;
    logic [5:0] phaseOffsetDeg;
  } switching_cfg_t;

  typedef struct packed {
    logic [1:0] inputRateSelect;
    logic inputRateValid;
    logic eightSlotHalfSelect;
    logic slotWidth16;
    logic pairSwap;
    logic [2:0] serialFormat;
    logic serialFormatValid;
  } serial_cfg_t;

  typedef struct packed {
    op_state_t ch1OperatingState;
    op_state_t ch2OperatingState;
  } chan_state_t;
endpackage

// ---- gain_ramp.sv ----
`timescale 1ns/1ns
`default_nettype none
module gain_ramp
  import amp_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic frameSyncPulse,
  input wire logic [1:0] rampRate,
  input wire logic [7:0] targetCode,
  output logic [7:0] currentCode,
  output logic channelMuted
);
  logic [2:0] frameCnt_r;
  logic [7:0] code_r;
  logic [2:0] frameLimit;
  logic stepNow;

  // one step every 1, 2, 4 or 8 frames
  assign frameLimit = 3'((4'h1 << rampRate) - ONE4);
  assign stepNow = frameSyncPulse && (frameCnt_r >= frameLimit);

  always_ff @(posedge mclk) begin
    if (rst) begin
      frameCnt_r <= 3'h0;
      code_r <= RST_GAIN;
    end else begin
      if (frameSyncPulse) begin
        frameCnt_r <= stepNow ? 3'h0 : frameCnt_r + 3'h1;
      end
      if (stepNow && code_r < targetCode) begin
        code_r <= code_r + ONE8;
      end else if (stepNow && code_r > targetCode) begin
        code_r <= code_r - ONE8;
      end
    end
  end

  assign currentCode = code_r;
  // code below 0x07 silences the channel completely
  assign channelMuted = code_r < GAIN_MUTE_BELOW;

  code_moves_a: assert property (@(posedge mclk) disable iff (rst)
    !$past(stepNow) && !$past(rst) |-> $stable(code_r))
    else $error("gain code moved without a ramp step");
  code_step_a: assert property (@(posedge mclk) disable iff (rst)
    stepNow && code_r != targetCode && $stable(targetCode)
      |=> code_r != $past(code_r))
    else $error("gain code failed to step toward target");
endmodule
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model
  import amp_cfg_pkg::*;
(
  input wire logic mclk,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regAddr = ZERO8;
    regWdata = ZERO8;
  end
  // callers send only defined codes, reserved bits as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(negedge mclk);
    regWrite <= 1'b0;
    // stale data inverted so a late sample cannot look right
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr <= a;
    @(negedge mclk);
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb
  import amp_cfg_pkg::*;
;
  logic mclk, rst, frameSyncPulse, regWrite, ch1Muted, ch2Muted;
  logic [7:0] regAddr, regWdata, regRdata, ch1Gain, ch2Gain, d, w, e;
  logic [1:0] rate;
  switching_cfg_t swCfg;
  serial_cfg_t serCfg;
  chan_state_t chState;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] rAddr [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h01, 8'h07};
  logic [7:0] rVal [7] = '{8'h62, 8'h04, 8'h55, 8'hcf, 8'hcf, 8'h32, 8'h00};
  logic [2:0] swCode [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  logic [5:0] swMul [5] = '{6'h08, 6'h0a, 6'h26, 6'h2c, 6'h30};
  logic [5:0] phDeg [4] = '{6'h00, 6'h1e, 6'h2d, 6'h3c};

  host_model host_model_inst (.mclk(mclk), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  audio_amp_config_registers audio_amp_config_registers_inst (.mclk(mclk), .rst(rst),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .frameSyncPulse(frameSyncPulse), .switchingCfg(swCfg), .serialCfg(serCfg),
    .chanState(chState), .ch1GainCode(ch1Gain), .ch2GainCode(ch2Gain),
    .ch1Muted(ch1Muted), .ch2Muted(ch2Muted));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge mclk);
      frameSyncPulse <= 1'b1;
      @(negedge mclk);
      frameSyncPulse <= 1'b0;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run is under a thousand cycles; ten thousand means a hang
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    frameSyncPulse = 1'b0;
    repeat (5) @(negedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      host_model_inst.rd(rAddr[i], d);
      chk("reset value", d, rVal[i]);
    end
    chk("reset multiple", swCfg.switchMultiple, 6'h2c);
    chk("reset ratio", swCfg.oversampleRatio, 8'h40);
    chk("reset phase", swCfg.phaseOffsetDeg, 6'h2d);
    chk("reset states", chState, {ST_HIZ, ST_HIZ});
    chk("reset gain", ch1Gain, 8'hcf);
    for (int i = 0; i < 5; i++) begin
      w = {1'b0, swCode[i], 1'b0, i[0], i[1:0]};
      host_model_inst.wr(ADDR_SWITCHING, w);
      chk("multiple", {swCfg.switchMultiple, swCfg.switchRateValid}, {swMul[i], 1'b1});
      chk("ratio", swCfg.oversampleRatio, i[0] ? 8'h80 : 8'h40);
      chk("phase", swCfg.phaseOffsetDeg, phDeg[i[1:0]]);
      chk("switching fields", {swCfg.switchRateSel, swCfg.modulatorOversampleSelect,
        swCfg.phaseOffsetSel}, {swCode[i], i[0], i[1:0]});
      host_model_inst.rd(ADDR_SWITCHING, d);
      chk("switching readback", d, w);
    end
    for (int i = 0; i < 7; i++) begin
      rate = 2'(i % 3);
      w = {rate, i[0], i[1], i[2], i[2:0]};
      host_model_inst.wr(ADDR_SERIAL, w);
      chk("serial", serCfg, {rate, 1'b1, i[0], i[1], i[2], i[2:0], 1'b1});
      host_model_inst.rd(ADDR_SERIAL, d);
      chk("serial readback", d, w);
    end
    for (int i = 0; i < 16; i++) begin
      host_model_inst.wr(ADDR_CHSTATE, {i[3:0], 4'h0});
      chk("states", chState, i[3:0]);
    end
    host_model_inst.wr(ADDR_GAIN1, 8'hd1);
    host_model_inst.wr(ADDR_GAIN2, 8'hcd);
    host_model_inst.rd(ADDR_GAIN1, d);
    chk("gain1 reg", d, 8'hd1);
    host_model_inst.rd(ADDR_GAIN2, d);
    chk("gain2 reg", d, 8'hcd);
    chk("gain held", ch1Gain, 8'hcf);
    pulse(2);
    chk("gain1 ramp", ch1Gain, 8'hd1);
    chk("gain2 ramp", ch2Gain, 8'hcd);
    host_model_inst.wr(ADDR_GAIN1, 8'hff);
    e = 8'hd1;
    for (int r = 0; r < 4; r++) begin
      host_model_inst.wr(ADDR_RAMP, {4'h3, 2'(r), 2'h2});
      pulse(1 << r);
      e = e + 8'h01;
      chk("ramp rate", ch1Gain, e);
    end
    host_model_inst.wr(ADDR_RAMP, 8'h32);
    host_model_inst.wr(ADDR_GAIN2, 8'h07);
    pulse(200);
    chk("gain top", {ch1Gain, 7'h00, ch1Muted}, 16'hff00);
    chk("gain floor", {ch2Gain, 7'h00, ch2Muted}, 16'h0700);
    host_model_inst.wr(ADDR_GAIN2, 8'h06);
    pulse(1);
    chk("gain muted", {ch2Gain, 7'h00, ch2Muted}, 16'h0601);
    give_verdict();
  end
endmodule
`default_nettype wire
